// ---- verilog/stream_read_pkg.sv ----
// constants and types shared by the stream read command logic
`default_nettype none
package stream_read_pkg;
  // task-file register indices on the plain register port
  localparam logic [3:0] REG_DATA        = 4'h0;
  localparam logic [3:0] REG_FEATURE     = 4'h1;
  localparam logic [3:0] REG_SECT_COUNT  = 4'h2;
  localparam logic [3:0] REG_SECT_NUMBER = 4'h3;
  localparam logic [3:0] REG_CYL_LOW     = 4'h4;
  localparam logic [3:0] REG_CYL_HIGH    = 4'h5;
  localparam logic [3:0] REG_DEVICE      = 4'h6;
  localparam logic [3:0] REG_COMMAND     = 4'h7;
  localparam logic [3:0] REG_CONTROL     = 4'h8;
  localparam logic [3:0] REG_TIME_UNIT   = 4'h9;
  localparam logic [3:0] REG_DEFAULT_LIM = 4'ha;
  localparam logic [3:0] REG_ERROR_LOG   = 4'hb;
  localparam logic [3:0] REG_MEDIA_CTRL  = 4'hc;
  localparam logic [7:0] OPCODE_STREAM_PIO = 8'h2b;
  localparam int CONTROL_HOB_BIT = 7;
  // feature current fields
  localparam int FEAT_URGENT_BIT = 7;
  localparam int FEAT_CONT_BIT   = 6;
  localparam int FEAT_NOSEQ_BIT  = 5;
  localparam int FEAT_RESUME_BIT = 4;
  // status and error bits
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_SE  = 5;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_CRC = 7;
  localparam int ER_UNC = 6;
  localparam int ER_IDN = 4;
  localparam int ER_ABT = 2;
  localparam int ER_COMPLETION_TIMEOUT_FLAG = 0;
  localparam logic [7:0] STATUS_RESET = 8'h40;
  localparam logic [15:0] TIME_UNIT_RESET = 16'h000a;
  localparam logic [23:0] MIN_LIMIT_US = 24'h000064;
  localparam int CLOCK_MHZ = 10;
  localparam logic [3:0] CYCLES_PER_US = 4'(CLOCK_MHZ);
  localparam logic [7:0] WORDS_PER_SECTOR = 8'hff;
  localparam int NUM_STREAMS = 8;
  typedef enum {ST_IDLE, ST_XFER, ST_DONE} state_type;
endpackage
`default_nettype wire

// ---- verilog/limit_if.sv ----
// carrier between command logic and its time-limit timer
`timescale 1ns/100ps
`default_nettype none
interface limit_if;
  logic        start;
  logic        stop;
  logic [23:0] limit_us;
  logic        enabled;
  logic        expired;
  modport ctrl (output start, output stop, output limit_us, output enabled, input expired);
  modport timer (input start, input stop, input limit_us, input enabled, output expired);
endinterface
`default_nettype wire

// ---- verilog/limit_timer.sv ----
// completion time limit timer counted in microseconds
`timescale 1ns/100ps
`default_nettype none
module limit_timer
(
  // clocking
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic ce,
  // control
  limit_if.timer   lim
);
  logic [3:0]  tick_q;
  logic [23:0] us_q;
  logic        run_q;
  logic        exp_q;
  assign lim.expired = exp_q;
  // microsecond prescaler and elapsed count
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      tick_q <= 4'h0;
      us_q <= 24'h000000;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end
    else if (ce)
    begin
      if (lim.start)
      begin
        tick_q <= 4'h0;
        us_q <= 24'h000000;
        run_q <= lim.enabled;
        exp_q <= 1'b0;
      end
      else if (lim.stop)
        run_q <= 1'b0;
      else if (run_q)
      begin
        if (tick_q == stream_read_pkg::CYCLES_PER_US - 4'h1)
        begin
          tick_q <= 4'h0;
          us_q <= us_q + 24'h000001;
          if (us_q + 24'h000001 >= lim.limit_us)
          begin
            exp_q <= 1'b1;
            run_q <= 1'b0;
          end
        end
        else
          tick_q <= tick_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/default_limit_mem.sv ----
// per-stream default time limit store with registered read
`timescale 1ns/100ps
`default_nettype none
module default_limit_mem
#(
  parameter int DEPTH = 8
)
(
  // clocking
  input wire logic                     CLOCK,
  input wire logic                     RST,
  input wire logic                     ce,
  // write side
  input wire logic                     wr,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [7:0]               wdata,
  // read side
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic     [8:0]               rdata
);
  // bit 8 marks that a configure was ever given for the entry
  logic [8:0] mem_q [DEPTH];
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_entry
      always_ff @(posedge CLOCK or posedge RST)
      begin
        if (RST)
          mem_q[g] <= 9'h000;
        else if (ce && wr && waddr == g)
          mem_q[g] <= {1'b1, wdata};
      end
    end
  endgenerate
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      rdata <= 9'h000;
    else if (ce)
      rdata <= mem_q[raddr];
  end
endmodule
`default_nettype wire

// ---- verilog/stream_read_command_exec.sv ----
// stream read pio command execution with time limit and error reporting
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - opcode 2Bh starts stream read PIO
// - count from both bytes, zero means 65536
// - 48-bit address from current and previous bytes
// - urgent commands still bounded by time limit
// - continuous read never aborts on errors
// - continuous flag clear gives normal streaming read
// - continuous errors: full length, SE, log type
// - continuous timeout: stop, SE, log timeout
// - try delivering full length within limit
// - resume flag restarts at last error address
// - low three feature bits select stream
// - limit is previous feature times time unit
// - zero limit uses stream default
// - zero or missing default disables limit
// - timing runs from command write to interrupt
// - short limit raised to built-in minimum
// - first error address returned via both views
// - timeout sets error bit 0
// - continuous error sets status bit 5
// - stream error returns address and bad count
// - continuous error keeps ERR clear, logs bits
module stream_read_command_exec
(
  // clocking
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire logic        CE,
  // register port
  input wire logic [3:0]  ADDR,
  input wire logic [15:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  output logic     [15:0] RDATA,
  // media side
  input wire logic        MEDIA_ERR,
  input wire logic [3:0]  MEDIA_ERR_TYPE,
  // host signals
  output logic            INTRQ,
  output logic            STREAM_START,
  output logic [2:0]      STREAM_ID,
  output logic            NOT_SEQUENTIAL,
  output logic            URGENT
);
  limit_if lim ();
  stream_read_pkg::state_type state_q;
  logic [7:0]  feat_cur_q, feat_prev_q, cnt_cur_q, cnt_prev_q;
  logic [7:0]  sn_cur_q, sn_prev_q, cl_cur_q, cl_prev_q, ch_cur_q, ch_prev_q;
  logic        hob_q;
  logic [15:0] time_unit_q;
  logic [7:0]  status_q, error_q, err_log_q;
  logic [47:0] lba_q, first_err_q;
  logic [16:0] remain_q;
  logic [15:0] bad_cnt_q;
  logic        err_seen_q;
  logic [7:0]  word_q;
  logic [47:0] last_err_q [stream_read_pkg::NUM_STREAMS];
  logic        start_q, stop_q, limit_en_q, pend_q;
  logic [23:0] limit_q;
  logic [8:0]  dflt_rd;
  logic        cmd_wr, cont_mode;
  logic [2:0]  sid;
  logic [16:0] req_len;
  logic [47:0] req_lba;
  logic [23:0] req_limit;
  logic [7:0]  err_bits;

  assign cmd_wr = WR && ADDR == stream_read_pkg::REG_COMMAND
                  && WDATA[7:0] == stream_read_pkg::OPCODE_STREAM_PIO;
  assign sid = feat_cur_q[2:0];
  assign cont_mode = feat_cur_q[stream_read_pkg::FEAT_CONT_BIT];
  assign req_len = ({cnt_prev_q, cnt_cur_q} == 16'h0000) ? 17'h10000
                   : {1'b0, cnt_prev_q, cnt_cur_q};
  assign req_lba = {ch_prev_q, cl_prev_q, sn_prev_q, ch_cur_q, cl_cur_q, sn_cur_q};
  assign req_limit = (feat_prev_q != 8'h00) ? {16'h0000, feat_prev_q} * {8'h00, time_unit_q}
                     : {16'h0000, dflt_rd[7:0]} * {8'h00, time_unit_q};
  assign err_bits = {MEDIA_ERR_TYPE[3:2], 1'b0, MEDIA_ERR_TYPE[1], 1'b0, MEDIA_ERR_TYPE[0],
                     2'b00};

  default_limit_mem #(.DEPTH(stream_read_pkg::NUM_STREAMS)) u_dflt
  (
    .CLOCK (CLOCK),
    .RST   (RST),
    .ce    (CE),
    .wr    (WR && ADDR == stream_read_pkg::REG_DEFAULT_LIM),
    .waddr (WDATA[10:8]),
    .wdata (WDATA[7:0]),
    .raddr (sid),
    .rdata (dflt_rd)
  );

  assign lim.start = start_q;
  assign lim.stop = stop_q;
  assign lim.limit_us = limit_q;
  assign lim.enabled = limit_en_q;

  limit_timer u_timer
  (
    .CLOCK (CLOCK),
    .RST   (RST),
    .ce    (CE),
    .lim   (lim)
  );

  // task-file writes shift the previous byte in, as for 48-bit addressing
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      feat_cur_q <= 8'h00;
      feat_prev_q <= 8'h00;
      cnt_cur_q <= 8'h00;
      cnt_prev_q <= 8'h00;
      sn_cur_q <= 8'h00;
      sn_prev_q <= 8'h00;
      cl_cur_q <= 8'h00;
      cl_prev_q <= 8'h00;
      ch_cur_q <= 8'h00;
      ch_prev_q <= 8'h00;
      hob_q <= 1'b0;
      time_unit_q <= stream_read_pkg::TIME_UNIT_RESET;
    end
    else if (CE && WR && state_q != stream_read_pkg::ST_XFER)
    begin
      case (ADDR)
        stream_read_pkg::REG_FEATURE:
        begin
          feat_prev_q <= feat_cur_q;
          feat_cur_q <= WDATA[7:0];
        end
        stream_read_pkg::REG_SECT_COUNT:
        begin
          cnt_prev_q <= cnt_cur_q;
          cnt_cur_q <= WDATA[7:0];
        end
        stream_read_pkg::REG_SECT_NUMBER:
        begin
          sn_prev_q <= sn_cur_q;
          sn_cur_q <= WDATA[7:0];
        end
        stream_read_pkg::REG_CYL_LOW:
        begin
          cl_prev_q <= cl_cur_q;
          cl_cur_q <= WDATA[7:0];
        end
        stream_read_pkg::REG_CYL_HIGH:
        begin
          ch_prev_q <= ch_cur_q;
          ch_cur_q <= WDATA[7:0];
        end
        stream_read_pkg::REG_CONTROL: hob_q <= WDATA[stream_read_pkg::CONTROL_HOB_BIT];
        stream_read_pkg::REG_TIME_UNIT: time_unit_q <= WDATA;
        default: ;
      endcase
    end
  end

  // the default lookup lands one cycle after the opcode, so the limit is chosen then
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      pend_q <= 1'b0;
      start_q <= 1'b0;
      limit_q <= 24'h000000;
      limit_en_q <= 1'b0;
    end
    else if (CE)
    begin
      pend_q <= cmd_wr && state_q != stream_read_pkg::ST_XFER;
      start_q <= pend_q;
      if (pend_q)
      begin
        limit_en_q <= (feat_prev_q != 8'h00) || (dflt_rd[8] && dflt_rd[7:0] != 8'h00);
        limit_q <= (req_limit < stream_read_pkg::MIN_LIMIT_US)
                   ? stream_read_pkg::MIN_LIMIT_US : req_limit;
      end
    end
  end

  // command sequencing; the urgent flag is passed on, the timer bounds it either way
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      state_q <= stream_read_pkg::ST_IDLE;
      status_q <= stream_read_pkg::STATUS_RESET;
      error_q <= 8'h00;
      err_log_q <= 8'h00;
      lba_q <= 48'h0;
      first_err_q <= 48'h0;
      remain_q <= 17'h0;
      bad_cnt_q <= 16'h0000;
      err_seen_q <= 1'b0;
      word_q <= 8'h00;
      stop_q <= 1'b0;
      INTRQ <= 1'b0;
      STREAM_START <= 1'b0;
      STREAM_ID <= 3'h0;
      NOT_SEQUENTIAL <= 1'b0;
      URGENT <= 1'b0;
      for (int i = 0; i < stream_read_pkg::NUM_STREAMS; i++)
        last_err_q[i] <= 48'h0;
    end
    else if (CE)
    begin
      stop_q <= 1'b0;
      STREAM_START <= 1'b0;
      case (state_q)
        stream_read_pkg::ST_IDLE, stream_read_pkg::ST_DONE:
        begin
          if (RD && ADDR == stream_read_pkg::REG_COMMAND)
            INTRQ <= 1'b0;
          if (start_q)
          begin
            state_q <= stream_read_pkg::ST_XFER;
            INTRQ <= 1'b0;
            status_q <= 8'h88;
            error_q <= 8'h00;
            err_log_q <= 8'h00;
            err_seen_q <= 1'b0;
            bad_cnt_q <= 16'h0000;
            remain_q <= req_len;
            word_q <= 8'h00;
            lba_q <= feat_cur_q[stream_read_pkg::FEAT_RESUME_BIT] ? last_err_q[sid]
                     : req_lba;
            STREAM_START <= 1'b1;
            STREAM_ID <= sid;
            NOT_SEQUENTIAL <= feat_cur_q[stream_read_pkg::FEAT_NOSEQ_BIT];
            URGENT <= feat_cur_q[stream_read_pkg::FEAT_URGENT_BIT];
          end
        end
        stream_read_pkg::ST_XFER:
        begin
          if (lim.expired)
          begin
            state_q <= stream_read_pkg::ST_DONE;
            stop_q <= 1'b1;
            INTRQ <= 1'b1;
            if (cont_mode)
            begin
              status_q <= 8'h60;
              err_log_q <= err_log_q | 8'h01;
            end
            else
            begin
              status_q <= 8'h41;
              error_q <= error_q | 8'h01;
            end
            if (!err_seen_q)
              first_err_q <= lba_q;
          end
          else if (RD && ADDR == stream_read_pkg::REG_DATA)
          begin
            word_q <= word_q + 8'h01;
            if (word_q == stream_read_pkg::WORDS_PER_SECTOR)
            begin
              lba_q <= lba_q + 48'h1;
              remain_q <= remain_q - 17'h1;
              if (MEDIA_ERR && !cont_mode)
              begin
                state_q <= stream_read_pkg::ST_DONE;
                stop_q <= 1'b1;
                INTRQ <= 1'b1;
                status_q <= 8'h41;
                error_q <= err_bits;
                first_err_q <= lba_q;
                last_err_q[sid] <= lba_q;
              end
              else
              begin
                if (MEDIA_ERR)
                begin
                  err_log_q <= err_log_q | err_bits;
                  if (!err_seen_q)
                  begin
                    first_err_q <= lba_q;
                    last_err_q[sid] <= lba_q;
                  end
                  err_seen_q <= 1'b1;
                  bad_cnt_q <= bad_cnt_q + 16'h0001;
                end
                if (remain_q == 17'h1)
                begin
                  state_q <= stream_read_pkg::ST_DONE;
                  stop_q <= 1'b1;
                  INTRQ <= 1'b1;
                  status_q <= (err_seen_q || MEDIA_ERR) ? 8'h60 : 8'h40;
                end
              end
            end
          end
        end
        default: state_q <= stream_read_pkg::ST_IDLE;
      endcase
    end
  end

  // register reads; address views follow the high-order select
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      RDATA <= 16'h0000;
    else if (CE)
    begin
      RDATA <= 16'h0000;
      if (RD)
      begin
        case (ADDR)
          stream_read_pkg::REG_DATA: RDATA <= {8'h00, word_q};
          stream_read_pkg::REG_FEATURE: RDATA <= {8'h00, error_q};
          stream_read_pkg::REG_SECT_COUNT:
            RDATA <= {8'h00, hob_q ? bad_cnt_q[15:8] : bad_cnt_q[7:0]};
          stream_read_pkg::REG_SECT_NUMBER:
            RDATA <= {8'h00, hob_q ? first_err_q[31:24] : first_err_q[7:0]};
          stream_read_pkg::REG_CYL_LOW:
            RDATA <= {8'h00, hob_q ? first_err_q[39:32] : first_err_q[15:8]};
          stream_read_pkg::REG_CYL_HIGH:
            RDATA <= {8'h00, hob_q ? first_err_q[47:40] : first_err_q[23:16]};
          stream_read_pkg::REG_COMMAND: RDATA <= {8'h00, status_q};
          stream_read_pkg::REG_TIME_UNIT: RDATA <= time_unit_q;
          stream_read_pkg::REG_ERROR_LOG: RDATA <= {8'h00, err_log_q};
          default: RDATA <= 16'h0000;
        endcase
      end
    end
  end

  property p_cont_no_err;
    @(posedge CLOCK) disable iff (RST)
      (state_q == stream_read_pkg::ST_DONE && cont_mode && $rose(INTRQ)) |-> !status_q[0];
  endproperty
  a_cont_no_err: assert property (p_cont_no_err) else $error("err in cont mode");
  property p_start;
    @(posedge CLOCK) disable iff (RST)
      (CE && cmd_wr && state_q != stream_read_pkg::ST_XFER) ##1 CE ##1 CE |=> STREAM_START;
  endproperty
  a_start: assert property (p_start) else $error("opcode did not start stream");
  property p_start_busy;
    @(posedge CLOCK) disable iff (RST)
      STREAM_START |-> status_q[stream_read_pkg::ST_BSY] && state_q == stream_read_pkg::ST_XFER;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start without busy");
  property p_limit_floor;
    @(posedge CLOCK) disable iff (RST)
      (CE && start_q && limit_en_q) |-> limit_q >= stream_read_pkg::MIN_LIMIT_US;
  endproperty
  a_limit_floor: assert property (p_limit_floor) else $error("limit below floor");
  property p_cont_timeout;
    @(posedge CLOCK) disable iff (RST)
      (CE && state_q == stream_read_pkg::ST_XFER && lim.expired && cont_mode)
      |=> status_q == 8'h60 && err_log_q[stream_read_pkg::ER_COMPLETION_TIMEOUT_FLAG];
  endproperty
  a_cont_timeout: assert property (p_cont_timeout) else $error("bad cont timeout end");
  property p_timeout_bit;
    @(posedge CLOCK) disable iff (RST)
      (CE && state_q == stream_read_pkg::ST_XFER && lim.expired && !cont_mode)
      |=> error_q[stream_read_pkg::ER_COMPLETION_TIMEOUT_FLAG] && status_q[stream_read_pkg::ST_ERR];
  endproperty
  a_timeout_bit: assert property (p_timeout_bit) else $error("timeout bit missing");
endmodule
`default_nettype wire

// ---- tb/host_ctrl_model.sv ----
// host controller model issuing task-file accesses to the stream read block
`timescale 1ns/100ps
`default_nettype none
module host_ctrl_model
(
  // clock
  input wire logic        clock,
  // register port
  output logic     [3:0]  addr,
  output logic     [15:0] wdata,
  output logic            wr,
  output logic            rd,
  input wire logic [15:0] rdata
);
  initial
  begin
    addr  = 4'h0;
    wdata = 16'h0000;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
    // scramble the idle data so a stale value is never mistaken for a write
    wdata <= ~v;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  // previous bytes go first so the second write of each pair is the current one
  task automatic issue(input logic [7:0] fcur, input logic [7:0] fprev,
                       input logic [15:0] cnt, input logic [47:0] lba, input logic [7:0] op);
    wr_reg(stream_read_pkg::REG_FEATURE, {8'h00, fprev});
    wr_reg(stream_read_pkg::REG_FEATURE, {8'h00, fcur});
    wr_reg(stream_read_pkg::REG_SECT_COUNT, {8'h00, cnt[15:8]});
    wr_reg(stream_read_pkg::REG_SECT_COUNT, {8'h00, cnt[7:0]});
    wr_reg(stream_read_pkg::REG_SECT_NUMBER, {8'h00, lba[31:24]});
    wr_reg(stream_read_pkg::REG_SECT_NUMBER, {8'h00, lba[7:0]});
    wr_reg(stream_read_pkg::REG_CYL_LOW, {8'h00, lba[39:32]});
    wr_reg(stream_read_pkg::REG_CYL_LOW, {8'h00, lba[15:8]});
    wr_reg(stream_read_pkg::REG_CYL_HIGH, {8'h00, lba[47:40]});
    wr_reg(stream_read_pkg::REG_CYL_HIGH, {8'h00, lba[23:16]});
    wr_reg(stream_read_pkg::REG_COMMAND, {8'h00, op});
  endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the stream read command block
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {logic [7:0] feat; logic [3:0] kind; logic bad; logic [7:0] st;
                         logic [7:0] er; logic [7:0] lg;} row_type;
  logic        clock;
  logic        rst;
  logic        ce;
  logic        media_err;
  logic [3:0]  media_kind;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        intrq;
  logic        sstart;
  logic [2:0]  sid;
  logic        nseq;
  logic        urgent_request;
  logic [15:0] d;
  int          n_mismatch;
  int          cmp_count;
  row_type     rows [6];

  stream_read_command_exec DUT
  (
    .CLOCK(clock), .RST(rst), .CE(ce),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .MEDIA_ERR(media_err), .MEDIA_ERR_TYPE(media_kind),
    .INTRQ(intrq), .STREAM_START(sstart), .STREAM_ID(sid),
    .NOT_SEQUENTIAL(nseq), .URGENT(urgent_request)
  );

  host_ctrl_model host
  (
    .clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata)
  );

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] v;
    host.rd_reg(a, v);
    chk(v, exp);
  endtask

  // bounded wait on the completion request or the start pulse
  task automatic wait_for(input bit irq, input int lim);
    int n;
    n = 0;
    while (((irq ? intrq : sstart) !== 1'b1) && n < lim)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    chk({15'h0000, irq ? intrq : sstart}, 16'h0001);
  endtask

  // the bad flag is raised only around the sector's final word
  task automatic read_sector(input logic bad, input logic [3:0] kind);
    for (int i = 0; i <= int'(stream_read_pkg::WORDS_PER_SECTOR); i++)
    begin
      if (i == int'(stream_read_pkg::WORDS_PER_SECTOR))
      begin
        @(posedge clock);
        media_err  <= bad;
        media_kind <= kind;
      end
      host.rd_reg(stream_read_pkg::REG_DATA, d);
    end
    @(posedge clock);
    media_err <= 1'b0;
  endtask

  task automatic tmo(input logic [7:0] feat, input logic [7:0] prev, input int quiet,
                     input logic [7:0] st, input logic [7:0] er);
    host.issue(feat, prev, 16'h0000, 48'h0, stream_read_pkg::OPCODE_STREAM_PIO);
    repeat (quiet) @(posedge clock);
    #1;
    chk({15'h0000, intrq}, 16'h0000);
    wait_for(1'b1, 120);
    rchk(stream_read_pkg::REG_COMMAND, {8'h00, st});
    rchk(stream_read_pkg::REG_FEATURE, {8'h00, er});
    if (feat[6])
      rchk(stream_read_pkg::REG_ERROR_LOG, 16'h0001);
    $display("timeout case done");
  endtask

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial
  begin
    repeat (30000) @(posedge clock);
    n_mismatch++;
    tally_and_finish();
  end

  initial
  begin
    rst        = 1'b1;
    ce         = 1'b1;
    media_err  = 1'b0;
    media_kind = 4'h0;
    n_mismatch = 0;
    cmp_count  = 0;
    rows[0] = {8'h03, 4'h0, 1'b0, 8'h40, 8'h00, 8'h00};
    rows[1] = {8'ha5, 4'h0, 1'b0, 8'h40, 8'h00, 8'h00};
    rows[2] = {8'h46, 4'h4, 1'b1, 8'h60, 8'h00, 8'h40};
    rows[3] = {8'h42, 4'h8, 1'b1, 8'h60, 8'h00, 8'h80};
    rows[4] = {8'h01, 4'h2, 1'b1, 8'h41, 8'h10, 8'h00};
    rows[5] = {8'h07, 4'h1, 1'b1, 8'h41, 8'h04, 8'h00};
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chk({15'h0000, intrq}, 16'h0000);
    rchk(stream_read_pkg::REG_COMMAND, {8'h00, stream_read_pkg::STATUS_RESET});
    $display("reset case done");
    // no default limit stored yet, so these rows run untimed
    foreach (rows[i])
    begin
      host.issue(rows[i].feat, 8'h00, 16'h0001, 48'h0, stream_read_pkg::OPCODE_STREAM_PIO);
      wait_for(1'b0, 8);
      chk({13'h0000, sid}, {13'h0000, rows[i].feat[2:0]});
      chk({15'h0000, urgent_request}, {15'h0000, rows[i].feat[7]});
      chk({15'h0000, nseq}, {15'h0000, rows[i].feat[5]});
      rchk(stream_read_pkg::REG_COMMAND, 16'h0088);
      read_sector(rows[i].bad, rows[i].kind);
      wait_for(1'b1, 50);
      rchk(stream_read_pkg::REG_COMMAND, {8'h00, rows[i].st});
      rchk(stream_read_pkg::REG_FEATURE, {8'h00, rows[i].er});
      if (rows[i].feat[6])
      begin
        rchk(stream_read_pkg::REG_ERROR_LOG, {8'h00, rows[i].lg});
        rchk(stream_read_pkg::REG_SECT_COUNT, 16'h0001);
      end
      $display("row %0d done", i);
    end
    // normal mode must stop at the bad second sector and never ask for the third
    host.issue(8'h04, 8'h00, 16'h0003, 48'h6655_4433_2211, stream_read_pkg::OPCODE_STREAM_PIO);
    wait_for(1'b0, 8);
    read_sector(1'b0, 4'h0);
    read_sector(1'b1, 4'h2);
    wait_for(1'b1, 50);
    rchk(stream_read_pkg::REG_COMMAND, 16'h0041);
    rchk(stream_read_pkg::REG_SECT_NUMBER, 16'h0012);
    rchk(stream_read_pkg::REG_CYL_LOW, 16'h0022);
    rchk(stream_read_pkg::REG_CYL_HIGH, 16'h0033);
    host.wr_reg(stream_read_pkg::REG_CONTROL, 16'h0080);
    rchk(stream_read_pkg::REG_SECT_NUMBER, 16'h0044);
    rchk(stream_read_pkg::REG_CYL_LOW, 16'h0055);
    rchk(stream_read_pkg::REG_CYL_HIGH, 16'h0066);
    host.wr_reg(stream_read_pkg::REG_CONTROL, 16'h0000);
    $display("error address case done");
    // resume on stream 4 must start at its last error, not at the issued address 0
    host.issue(8'h54, 8'h00, 16'h0001, 48'h0, stream_read_pkg::OPCODE_STREAM_PIO);
    wait_for(1'b0, 8);
    read_sector(1'b1, 4'h1);
    wait_for(1'b1, 50);
    rchk(stream_read_pkg::REG_SECT_NUMBER, 16'h0012);
    rchk(stream_read_pkg::REG_CYL_HIGH, 16'h0033);
    rchk(stream_read_pkg::REG_ERROR_LOG, 16'h0004);
    $display("resume case done");
    // one microsecond unit, stored default of one: clamped up to the 100 us floor
    host.wr_reg(stream_read_pkg::REG_TIME_UNIT, 16'h0001);
    host.wr_reg(stream_read_pkg::REG_DEFAULT_LIM, {5'h00, 3'h2, 8'h01});
    tmo(8'h42, 8'h00, 940, 8'h60, 8'h00);
    // 2 x 60 us = 1200 cycles, above the floor
    host.wr_reg(stream_read_pkg::REG_TIME_UNIT, 16'h003c);
    tmo(8'h01, 8'h02, 1140, 8'h41, 8'h01);
    // a write while the enable is low must leave the register untouched
    @(posedge clock);
    ce <= 1'b0;
    host.wr_reg(stream_read_pkg::REG_TIME_UNIT, 16'h0005);
    @(posedge clock);
    ce <= 1'b1;
    rchk(stream_read_pkg::REG_TIME_UNIT, 16'h003c);
    $display("clock enable case done");
    host.wr_reg(stream_read_pkg::REG_COMMAND, 16'h0020);
    repeat (6)
    begin
      @(posedge clock);
      #1;
      chk({15'h0000, sstart}, 16'h0000);
    end
    $display("foreign opcode case done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
